// ---- cax_defines.vh ----
`ifndef CAX_DEFINES_VH
`define CAX_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets on the Avalon-MM slave
// ----------------------------------------------------------------
`define CAX_OFS_ACC 6'h00
`define CAX_OFS_STATUS 6'h04
`define CAX_OFS_INSTR 6'h08
`define CAX_OFS_FADDR 6'h0c
`define CAX_OFS_FDATA 6'h10
`define CAX_OFS_DIR_A 6'h14
`define CAX_OFS_DIR_B 6'h18
`define CAX_OFS_DIR_C 6'h1c
`define CAX_OFS_WDOG 6'h20
`define CAX_OFS_CTRL 6'h24

// ----------------------------------------------------------------
// Status and control register bit positions
// ----------------------------------------------------------------
`define CAX_ST_C 0
`define CAX_ST_NIB 1
`define CAX_ST_Z 2
`define CAX_ST_PWDN 3
`define CAX_ST_TEXP 4
`define CAX_ST_SLEEP 5
`define CAX_CTRL_WAKE 0

// ----------------------------------------------------------------
// Instruction word fields
// ----------------------------------------------------------------
`define CAX_IN_LIT 7:0
`define CAX_IN_F 14:8
`define CAX_IN_D 15
`define CAX_IN_OP 19:16
`define CAX_IN_W 20

// ----------------------------------------------------------------
// Operation codes
// ----------------------------------------------------------------
`define CAX_OP_ROTR 4'h0
`define CAX_OP_SUBL 4'h1
`define CAX_OP_SUBF 4'h2
`define CAX_OP_SUBFB 4'h3
`define CAX_OP_SWAP 4'h4
`define CAX_OP_DIR 4'h5
`define CAX_OP_XORL 4'h6
`define CAX_OP_XORF 4'h7
`define CAX_OP_SLEEP 4'h8

// ----------------------------------------------------------------
// Direction register selectors and reset values
// ----------------------------------------------------------------
`define CAX_SEL_A 7'h05
`define CAX_SEL_B 7'h06
`define CAX_SEL_C 7'h07
`define CAX_DIR_RST 8'hff
`define CAX_ACC_RST 8'h00
`define CAX_BYTE_ZERO 8'h00

// ----------------------------------------------------------------
// Bus timing: extra service cycles before the answer
// ----------------------------------------------------------------
`define CAX_SVC_WAIT 2'd1

`endif

// ---- cax_file_mem.v ----
`timescale 1ns/10ps

// Register file: single address, write-first, registered read data
module cax_file_mem #(
    parameter AW = 7,
    parameter DW = 8
)(
    input wire clk,
    input wire rstn,
    input wire [AW-1:0] addr,
    input wire we,
    input wire [DW-1:0] wdata,
    output reg [DW-1:0] rdata
);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    reg [DW-1:0] mem_r [0:(1<<AW)-1]; // Not reset, like real SRAM

    // Write, then read back; a write shows up on the read port at once
    always @(posedge clk)
    begin
        if (we)
        begin
            mem_r[addr] <= wdata;
        end
    end

    // Read register; forwarding avoids a stale byte after a write
    always @(posedge clk)
    begin
        if (!rstn)
        begin
            rdata <= {DW{1'b0}};
        end
        else if (we)
        begin
            rdata <= wdata;
        end
        else
        begin
            rdata <= mem_r[addr];
        end
    end

endmodule

// ---- cax_exec.v ----
`timescale 1ns/10ps
`include "cax_defines.vh"

module cax_exec #(
    parameter PRE_W = 8,
    parameter FA_W = 7
)(
    input wire clk,
    input wire rstn,
    input wire [5:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output wire avs_waitrequest,
    output wire [7:0] port_a_direction,
    output wire [7:0] port_b_direction,
    output wire [7:0] port_c_direction,
    output wire sleep_mode,
    output wire osc_run
);

    // ----------------------------------------------------------------
    // Execution states
    // ----------------------------------------------------------------
    localparam ST_IDLE = 2'b00; // Waiting for an instruction
    localparam ST_RD = 2'b01; // Register operand being fetched
    localparam ST_EX = 2'b10; // Operand valid, results committed

    // ----------------------------------------------------------------
    // State and registers
    // ----------------------------------------------------------------
    reg [1:0] state_r; // Execution state
    reg [7:0] acc_r; // Accumulator
    reg carry_r; // Carry / not-borrow
    reg nibble_arith_flag_r; // Low nibble carry
    reg zero_r; // Zero flag
    reg powerdown_flag_r; // Cleared by sleep
    reg time_expired_flag_r; // Set by sleep, cleared on timeout
    reg sleep_r; // Core asleep
    reg [7:0] port_a_direction_r; // Direction register A
    reg [7:0] port_b_direction_r; // Direction register B
    reg [7:0] port_c_direction_r; // Direction register C
    reg [20:0] instr_r; // Last instruction written
    reg [FA_W-1:0] faddr_r; // Software file window address
    reg [1:0] svc_cnt_r; // Bus service delay counter
    reg ack_r; // Bus answer cycle
    reg [7:0] watchdog_counter_r; // Watchdog count
    reg [PRE_W-1:0] pre_r; // Watchdog prescaler

    // ----------------------------------------------------------------
    // Bus decode
    // ----------------------------------------------------------------
    wire req = avs_read | avs_write; // Any request pending
    wire commit = req & ack_r; // Edge at which the master sees no wait
    wire wr_com = commit & avs_write; // Write takes effect here
    wire wr_acc = wr_com & (avs_address == `CAX_OFS_ACC);
    wire wr_stat = wr_com & (avs_address == `CAX_OFS_STATUS);
    wire wr_instr = wr_com & (avs_address == `CAX_OFS_INSTR);
    wire wr_faddr = wr_com & (avs_address == `CAX_OFS_FADDR);
    wire wr_fdata = wr_com & (avs_address == `CAX_OFS_FDATA);
    wire wr_ctrl = wr_com & (avs_address == `CAX_OFS_CTRL);

    // Wait until the answer is ready; refuse service while executing
    assign avs_waitrequest = req & ~ack_r;

    // ----------------------------------------------------------------
    // Instruction fields
    // ----------------------------------------------------------------
    wire [3:0] op = instr_r[`CAX_IN_OP]; // Operation code
    wire [7:0] lit = instr_r[`CAX_IN_LIT]; // Immediate byte
    wire [FA_W-1:0] fsel = instr_r[`CAX_IN_F]; // Register operand address
    wire dsel = instr_r[`CAX_IN_D]; // Destination bit

    // ----------------------------------------------------------------
    // Register file port
    // ----------------------------------------------------------------
    wire [7:0] fval; // Operand read back from the file
    reg [FA_W-1:0] mem_addr; // Shared address
    reg mem_we; // Shared write strobe
    reg [7:0] mem_wdata; // Shared write data

    // ----------------------------------------------------------------
    // ALU results
    // ----------------------------------------------------------------
    reg [7:0] res_nxt; // Result byte
    reg c_nxt; // New carry
    reg nib_nxt; // New nibble carry
    reg upd_c; // Carry is written
    reg upd_nib; // Nibble carry is written
    reg upd_z; // Zero is written
    reg uses_dest; // Destination bit steers the result
    reg to_acc; // Literal form always writes the accumulator
    reg [7:0] sub_a; // Minuend
    reg sub_cin; // Carry into subtraction, 1 = no borrow
    reg [8:0] sum9; // Minuend plus inverted accumulator
    reg [4:0] sum5; // Low nibble of the same sum

    // Operand fetched one cycle after the address, hence ST_RD
    cax_file_mem #(
        .AW(FA_W),
        .DW(8)
    ) u_mem (
        .clk(clk),
        .rstn(rstn),
        .addr(mem_addr),
        .we(mem_we),
        .wdata(mem_wdata),
        .rdata(fval)
    );

    // ----------------------------------------------------------------
    // Combinational datapath
    // ----------------------------------------------------------------
    // Subtract is add of inverted accumulator plus carry in
    always @*
    begin
        res_nxt = `CAX_BYTE_ZERO;
        c_nxt = carry_r;
        nib_nxt = nibble_arith_flag_r;
        upd_c = 1'b0;
        upd_nib = 1'b0;
        upd_z = 1'b0;
        uses_dest = 1'b0;
        to_acc = 1'b0;
        sub_a = (op == `CAX_OP_SUBL) ? lit : fval;
        // Clear carry counts as a borrow for the borrow form
        sub_cin = (op == `CAX_OP_SUBFB) ? carry_r : 1'b1;
        sum9 = {1'b0, sub_a} + {1'b0, ~acc_r} + {8'h00, sub_cin};
        sum5 = {1'b0, sub_a[3:0]} + {1'b0, ~acc_r[3:0]} + {4'h0, sub_cin};
        case (op)
            `CAX_OP_ROTR:
            begin
                // Old carry into bit 7, bit 0 out to carry
                res_nxt = {carry_r, fval[7:1]};
                c_nxt = fval[0];
                upd_c = 1'b1;
                uses_dest = 1'b1;
            end
            `CAX_OP_SUBL:
            begin
                // Carry set when accumulator <= literal
                res_nxt = sum9[7:0];
                c_nxt = sum9[8];
                nib_nxt = sum5[4];
                upd_c = 1'b1;
                upd_nib = 1'b1;
                upd_z = 1'b1;
                to_acc = 1'b1;
            end
            `CAX_OP_SUBF, `CAX_OP_SUBFB:
            begin
                res_nxt = sum9[7:0];
                c_nxt = sum9[8];
                nib_nxt = sum5[4];
                upd_c = 1'b1;
                upd_nib = 1'b1;
                upd_z = 1'b1;
                uses_dest = 1'b1;
            end
            `CAX_OP_SWAP:
            begin
                // No flag touched
                res_nxt = {fval[3:0], fval[7:4]};
                uses_dest = 1'b1;
            end
            `CAX_OP_XORL:
            begin
                res_nxt = acc_r ^ lit;
                upd_z = 1'b1;
                to_acc = 1'b1;
            end
            `CAX_OP_XORF:
            begin
                res_nxt = acc_r ^ fval;
                upd_z = 1'b1;
                uses_dest = 1'b1;
            end
            default:
            begin
                res_nxt = `CAX_BYTE_ZERO; // Direction load and sleep
            end
        endcase
    end

    // ----------------------------------------------------------------
    // Register file port mux
    // ----------------------------------------------------------------
    // Bus only commits in idle, so the two writers never collide
    always @*
    begin
        mem_addr = (state_r == ST_IDLE) ? faddr_r : fsel;
        mem_we = 1'b0;
        mem_wdata = avs_writedata[7:0];
        if (state_r == ST_EX)
        begin
            mem_we = uses_dest & dsel;
            mem_wdata = res_nxt;
        end
        else if (wr_fdata)
        begin
            mem_we = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Execution state machine
    // ----------------------------------------------------------------
    // Instructions written while asleep are stored in instr_r but not started: sleep_r keeps ST_IDLE
    always @(posedge clk)
    begin
        if (!rstn)
        begin
            state_r <= ST_IDLE;
            instr_r <= 21'h0_0000;
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                begin
                    if (wr_instr)
                    begin
                        instr_r <= avs_writedata[20:0];
                        if (!sleep_r)
                        begin
                            state_r <= ST_RD;
                        end
                    end
                end
                ST_RD:
                begin
                    state_r <= ST_EX; // Operand now on fval
                end
                ST_EX:
                begin
                    state_r <= ST_IDLE;
                end
                default:
                begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Accumulator, flags and direction registers
    // ----------------------------------------------------------------
    always @(posedge clk)
    begin
        if (!rstn)
        begin
            acc_r <= `CAX_ACC_RST;
            carry_r <= 1'b0;
            nibble_arith_flag_r <= 1'b0;
            zero_r <= 1'b0;
            port_a_direction_r <= `CAX_DIR_RST;
            port_b_direction_r <= `CAX_DIR_RST;
            port_c_direction_r <= `CAX_DIR_RST;
        end
        else if (state_r == ST_EX)
        begin
            // Destination bit clear, or literal form: accumulator
            if (to_acc || (uses_dest && !dsel))
            begin
                acc_r <= res_nxt;
            end
            if (upd_c)
            begin
                carry_r <= c_nxt;
            end
            if (upd_nib)
            begin
                nibble_arith_flag_r <= nib_nxt;
            end
            if (upd_z)
            begin
                zero_r <= (res_nxt == `CAX_BYTE_ZERO);
            end
            // Out-of-range selector loads nothing
            if (op == `CAX_OP_DIR)
            begin
                if (fsel == `CAX_SEL_A)
                begin
                    port_a_direction_r <= acc_r;
                end
                if (fsel == `CAX_SEL_B)
                begin
                    port_b_direction_r <= acc_r;
                end
                if (fsel == `CAX_SEL_C)
                begin
                    port_c_direction_r <= acc_r;
                end
            end
        end
        else
        begin
            if (wr_acc)
            begin
                acc_r <= avs_writedata[7:0];
            end
            if (wr_stat)
            begin
                carry_r <= avs_writedata[`CAX_ST_C];
                nibble_arith_flag_r <= avs_writedata[`CAX_ST_NIB];
                zero_r <= avs_writedata[`CAX_ST_Z];
            end
        end
    end

    // ----------------------------------------------------------------
    // Watchdog, sleep and power status
    // ----------------------------------------------------------------
    wire pre_full = &pre_r; // Prescaler about to wrap
    wire wdog_ovf = pre_full & (&watchdog_counter_r); // Time-out event
    wire do_sleep = (state_r == ST_EX) & (op == `CAX_OP_SLEEP);

    // Watchdog keeps counting in sleep; its own clock is not stopped
    always @(posedge clk)
    begin
        if (!rstn)
        begin
            pre_r <= {PRE_W{1'b0}};
            watchdog_counter_r <= 8'h00;
        end
        else if (do_sleep)
        begin
            pre_r <= {PRE_W{1'b0}};
            watchdog_counter_r <= 8'h00;
        end
        else
        begin
            pre_r <= pre_r + {{(PRE_W-1){1'b0}}, 1'b1};
            if (pre_full)
            begin
                watchdog_counter_r <= watchdog_counter_r + 8'h01;
            end
        end
    end

    // Time-out wins over a wake write arriving in the same cycle
    always @(posedge clk)
    begin
        if (!rstn)
        begin
            powerdown_flag_r <= 1'b1;
            time_expired_flag_r <= 1'b1;
            sleep_r <= 1'b0;
        end
        else if (do_sleep)
        begin
            powerdown_flag_r <= 1'b0;
            time_expired_flag_r <= 1'b1;
            sleep_r <= 1'b1;
        end
        else
        begin
            if (wdog_ovf)
            begin
                time_expired_flag_r <= 1'b0;
                sleep_r <= 1'b0;
            end
            else if (wr_ctrl && avs_writedata[`CAX_CTRL_WAKE])
            begin
                sleep_r <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Bus answer and read data
    // ----------------------------------------------------------------
    // Two wait cycles let the file read settle after an address change
    always @(posedge clk)
    begin
        if (!rstn)
        begin
            ack_r <= 1'b0;
            svc_cnt_r <= 2'd0;
            avs_readdata <= 32'h0000_0000;
        end
        else if (ack_r)
        begin
            ack_r <= 1'b0;
            svc_cnt_r <= 2'd0;
        end
        else if (req && state_r == ST_IDLE && !(wr_instr))
        begin
            if (svc_cnt_r == `CAX_SVC_WAIT)
            begin
                ack_r <= 1'b1;
                avs_readdata <= 32'h0000_0000;
                case (avs_address)
                    `CAX_OFS_ACC: avs_readdata[7:0] <= acc_r;
                    `CAX_OFS_STATUS: avs_readdata[5:0] <= {sleep_r,
                        time_expired_flag_r, powerdown_flag_r, zero_r,
                        nibble_arith_flag_r, carry_r};
                    `CAX_OFS_INSTR: avs_readdata[20:0] <= instr_r;
                    `CAX_OFS_FADDR: avs_readdata[FA_W-1:0] <= faddr_r;
                    `CAX_OFS_FDATA: avs_readdata[7:0] <= fval;
                    `CAX_OFS_DIR_A: avs_readdata[7:0] <= port_a_direction_r;
                    `CAX_OFS_DIR_B: avs_readdata[7:0] <= port_b_direction_r;
                    `CAX_OFS_DIR_C: avs_readdata[7:0] <= port_c_direction_r;
                    `CAX_OFS_WDOG: avs_readdata[7:0] <= watchdog_counter_r;
                    default: avs_readdata <= 32'h0000_0000; // Unmapped
                endcase
            end
            else
            begin
                svc_cnt_r <= svc_cnt_r + 2'd1;
            end
        end
        else
        begin
            svc_cnt_r <= 2'd0; // No request, or busy: restart the delay
        end
    end

    // Software file window address
    always @(posedge clk)
    begin
        if (!rstn)
        begin
            faddr_r <= {FA_W{1'b0}};
        end
        else if (wr_faddr)
        begin
            faddr_r <= avs_writedata[FA_W-1:0];
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign port_a_direction = port_a_direction_r;
    assign port_b_direction = port_b_direction_r;
    assign port_c_direction = port_c_direction_r;
    assign sleep_mode = sleep_r;
    assign osc_run = ~sleep_r;

endmodule

// ---- cax_exec_sva.sv ----
`timescale 1ns/10ps
`include "cax_defines.vh"
// ------------------------------------------------
// Port checker for the execution block
// ------------------------------------------------
module cax_exec_chk #(
    parameter PRE_W = 8,
    parameter FA_W = 7
)(
    input wire clk,
    input wire rstn,
    input wire [5:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [31:0] avs_readdata,
    input wire avs_waitrequest,
    input wire [7:0] port_a_direction,
    input wire [7:0] port_b_direction,
    input wire [7:0] port_c_direction,
    input wire sleep_mode,
    input wire osc_run
);
    // Any bus request pending
    wire req = avs_read || avs_write;
    // Instruction word committed this cycle
    wire cmt = avs_write && !avs_waitrequest && (avs_address == `CAX_OFS_INSTR);
    wire [3:0] cop = avs_writedata[`CAX_IN_OP];
    wire [6:0] cf = avs_writedata[`CAX_IN_F];
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_answer; req |-> ##[0:6] !avs_waitrequest; endproperty
    property p_one_low; req && !avs_waitrequest |-> $past(avs_waitrequest); endproperty
    property p_idle; !req |-> !avs_waitrequest; endproperty
    property p_rd_hold; $changed(avs_readdata) |-> req && !avs_waitrequest; endproperty
    property p_osc; osc_run == !sleep_mode; endproperty
    // Commit edge, decode, execute: visible three edges later
    property p_sleep; cmt && cop == `CAX_OP_SLEEP && !sleep_mode |-> ##3 sleep_mode; endproperty
    property p_dir_a;
        $changed(port_a_direction) |-> $past(cmt && cop == `CAX_OP_DIR && cf == `CAX_SEL_A, 3);
    endproperty
    property p_dir_one;
        $changed(port_b_direction) |-> $stable(port_a_direction) && $stable(port_c_direction);
    endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    a_one_low: assert property (p_one_low) else $error("waitrequest low too long");
    a_idle: assert property (p_idle) else $error("waitrequest while idle");
    a_rd_hold: assert property (p_rd_hold) else $error("readdata moved");
    a_osc: assert property (p_osc) else $error("oscillator state wrong");
    a_sleep: assert property (p_sleep) else $error("sleep not entered");
    a_dir_a: assert property (p_dir_a) else $error("dir A changed");
    a_dir_one: assert property (p_dir_one) else $error("two dirs changed");
    c_sleep: cover property ($rose(sleep_mode));
    c_dir: cover property ($changed(port_c_direction));
    c_read: cover property (avs_read && !avs_waitrequest);
endmodule
bind cax_exec cax_exec_chk #(.PRE_W(PRE_W), .FA_W(FA_W)) u_chk (
    .clk(clk), .rstn(rstn), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .port_a_direction(port_a_direction),
    .port_b_direction(port_b_direction), .port_c_direction(port_c_direction),
    .sleep_mode(sleep_mode), .osc_run(osc_run));

// ---- testbench.sv ----
`timescale 1ns/10ps
`include "cax_defines.vh"
// ------------------------------------------------
// Self-checking bench with integer reference model
// ------------------------------------------------
module testbench;
    reg clk;
    reg rstn;
    reg [5:0] avs_address;
    reg avs_read;
    reg avs_write;
    reg [31:0] avs_writedata;
    wire [31:0] avs_readdata;
    wire avs_waitrequest;
    wire [7:0] port_a_direction;
    wire [7:0] port_b_direction;
    wire [7:0] port_c_direction;
    wire sleep_mode;
    wire osc_run;
    integer err_count = 0;
    integer cmp_count = 0;
    integer seed = 8373;
    integer i, op, f, d, lit, src, res, t, acc, c, nb, z;
    integer mem [0:127];
    integer dir [5:7];
    reg [31:0] rd;
    // Short watchdog prescaler keeps the run brief
    cax_exec #(.PRE_W(2), .FA_W(7)) uut (.clk(clk), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .port_a_direction(port_a_direction), .port_b_direction(port_b_direction),
        .port_c_direction(port_c_direction), .sleep_mode(sleep_mode), .osc_run(osc_run));
    initial
    begin
        clk = 0;
        forever #5 clk = ~clk;
    end
    task finish_test;
    begin
        if (err_count == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    end
    endtask
    task chk(input [31:0] got, input [31:0] exp);
    begin
        cmp_count = cmp_count + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    end
    endtask
    // One Avalon access; waitrequest and read data taken at the same rising edge
    task bus(input w, input [5:0] a, input [31:0] wd);
        integer n;
    begin
        n = 0;
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= w;
        avs_read <= !w;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0 && n < 50)
        begin
            @(posedge clk);
            n = n + 1;
        end
        if (n >= 50)
        begin
            err_count = err_count + 1;
            $display("MISMATCH %0t bus timeout", $time);
            finish_test;
        end
        rd = avs_readdata;
        avs_write <= 0;
        avs_read <= 0;
        // Idle edge between accesses, so no strobe is driven twice at once
        @(posedge clk);
    end
    endtask
    task exec(input integer o, input integer fa, input integer dd, input integer lt);
        bus(1, `CAX_OFS_INSTR, {12'h000, o[3:0], dd[0], fa[6:0], lt[7:0]});
    endtask
    task check_state;
    begin
        bus(0, `CAX_OFS_ACC, 0);
        chk(rd, acc);
        bus(0, `CAX_OFS_STATUS, 0);
        chk({29'h0, rd[2:0]}, {29'h0, z[0], nb[0], c[0]});
    end
    endtask
    // Reference model of one instruction
    task model;
    begin
        src = (op == 1 || op == 6) ? lit : mem[f];
        t = 1 - c;
        case (op)
            0: begin res = (c << 7) | (src >> 1); c = src & 1; end
            1, 2: begin res = (src - acc) & 255; nb = (src & 15) >= (acc & 15);
                c = src >= acc; z = (res == 0); end
            3: begin res = (src - acc - t) & 255; nb = (src & 15) >= (acc & 15) + t;
                c = src >= acc + t; z = (res == 0); end
            4: res = ((src & 15) << 4) | (src >> 4);
            default: begin res = acc ^ src; z = (res == 0); end
        endcase
        if (op == 1 || op == 6 || d == 0) acc = res; else mem[f] = res;
    end
    endtask
    initial
    begin
        rstn = 0;
        avs_address = 0;
        avs_read = 0;
        avs_write = 0;
        avs_writedata = 0;
        acc = 0; c = 0; nb = 0; z = 0;
        for (i = 5; i < 8; i = i + 1) dir[i] = 255;
        repeat (12) @(posedge clk);
        rstn <= 1;
        // First request only after the first edge with reset released
        @(posedge clk);
        chk({8'h00, port_a_direction, port_b_direction, port_c_direction}, 32'h00ff_ffff);
        bus(0, `CAX_OFS_STATUS, 0);
        chk(rd, 32'h0000_0018);
        bus(0, 6'h3c, 0);
        chk(rd, 32'h0000_0000);
        for (i = 16; i < 24; i = i + 1)
        begin
            mem[i] = $random(seed) & 255;
            bus(1, `CAX_OFS_FADDR, i);
            bus(1, `CAX_OFS_FDATA, mem[i]);
        end
        // Random instruction mix; every eighth loads the accumulator with the register operand
        for (i = 0; i < 80; i = i + 1)
        begin
            op = $random(seed) & 7;
            if (op == 5) op = 0;
            f = 16 + ($random(seed) & 7);
            d = $random(seed) & 1;
            lit = $random(seed) & 255;
            if ((i & 7) == 0) begin acc = mem[f]; bus(1, `CAX_OFS_ACC, acc); end
            model;
            exec(op, f, d, lit);
            check_state;
            bus(1, `CAX_OFS_FADDR, f);
            bus(0, `CAX_OFS_FDATA, 0);
            chk(rd, mem[f]);
        end
        // Direction loads, selectors just outside the range included
        for (f = 4; f < 9; f = f + 1)
        begin
            acc = $random(seed) & 255;
            bus(1, `CAX_OFS_ACC, acc);
            exec(5, f, 0, 0);
            if (f >= 5 && f <= 7) dir[f] = acc;
            check_state;
            chk({8'h00, port_a_direction, port_b_direction, port_c_direction},
                {8'h00, dir[5][7:0], dir[6][7:0], dir[7][7:0]});
        end
        // Let the watchdog count up before sleeping
        repeat (300) @(posedge clk);
        exec(8, 0, 0, 0);
        bus(0, `CAX_OFS_STATUS, 0);
        chk({29'h0, rd[5:3]}, 32'h0000_0006);
        chk({30'h0, sleep_mode, osc_run}, 32'h0000_0002);
        bus(0, `CAX_OFS_WDOG, 0);
        chk({31'h0, rd < 5}, 32'h0000_0001);
        // Instruction written while asleep must not execute
        exec(6, 0, 0, 90);
        check_state;
        bus(1, `CAX_OFS_CTRL, 1);
        bus(0, `CAX_OFS_STATUS, 0);
        chk({31'h0, rd[5]}, 32'h0000_0000);
        check_state;
        // Sleep again; watchdog expiry wakes the core and clears time-expired
        exec(8, 0, 0, 0);
        repeat (1040) @(posedge clk);
        bus(0, `CAX_OFS_STATUS, 0);
        chk({29'h0, rd[5:3]}, 32'h0000_0000);
        chk({30'h0, sleep_mode, osc_run}, 32'h0000_0001);
        finish_test;
    end
endmodule
